// *** bmd_cfg.svh ***
/*
 banked data-memory decoder: offsets, field positions, reset values, sizes.
 assumes inclusion by the package and the design modules only.
*/
`ifndef BMD_CFG_SVH
`define BMD_CFG_SVH

// in-bank offsets (register index; byte address is four times the index)
`define BMD_OFF_INDIRECT   7'h00
`define BMD_OFF_STATUS     7'h03
`define BMD_OFF_POINTER    7'h04
`define BMD_OFF_LAST       7'h7f
// special function region is the lowest offsets of each bank
`define BMD_SFR_TOP        7'h1f
// common area redirected to bank 0
`define BMD_COMMON_LO      7'h70
// general storage windows per bank
`define BMD_GPR0_LO        7'h20
`define BMD_GPR1_LO        7'h20
`define BMD_GPR1_HI_LARGE  7'h6f
`define BMD_GPR1_HI_SMALL  7'h3f
`define BMD_GPR2_LO        7'h20
`define BMD_GPR2_HI_LARGE  7'h2f
// physical base of each bank's general storage
`define BMD_GPR0_BASE      8'h00
`define BMD_GPR1_BASE      8'h60
`define BMD_GPR2_BASE      8'hb0
// sizes
`define BMD_GPR_DEPTH      192
`define BMD_SFR_DEPTH      128
// core status field positions
`define BMD_BANK_HI_BIT    6
`define BMD_BANK_LO_BIT    5
`define BMD_IND_BANK_BIT   7
// reset values
`define BMD_STATUS_RST     8'h00
`define BMD_POINTER_RST    8'h00
// bus read value for unimplemented locations
`define BMD_UNMAPPED_DATA  8'h00

`endif

// *** bmd_pkg.sv ***
/*
 types of the banked data-memory decoder.
 assumes bmd_cfg.svh is on the include path.
*/
`include "bmd_cfg.svh"

package bmd_pkg;

	typedef logic [1:0] bmd_bank_t;
	typedef logic [6:0] bmd_off_t;

	// decoded physical location of one file access
	typedef struct packed {
		logic       is_sfr;
		logic [6:0] sfr_idx;
		logic       is_gpr;
		logic [7:0] gpr_idx;
	} bmd_loc_t;

	typedef struct packed {
		logic                                 waitreq;
		logic [7:0]                           rdata;
		logic [7:0]                           status;
		logic [7:0]                           pointer;
		logic [`BMD_SFR_DEPTH-1:0][7:0]       special_function_location;
		logic [`BMD_GPR_DEPTH-1:0][7:0]       general_storage_location;
	} bmd_state_t;

endpackage

// *** bmd_map.sv ***
/*
 combinational map from bank and in-bank offset to a physical location.
 assumes the caller handles the indirect slot and the core registers.
*/
`include "bmd_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module bmd_map (
	input  wire logic              i_large,
	input  wire bmd_pkg::bmd_bank_t i_bank,
	input  wire bmd_pkg::bmd_off_t  i_off,
	output var  bmd_pkg::bmd_loc_t  o_loc
);

	logic [1:0] bank;
	logic [6:0] gpr1_hi;

	always_comb begin
		o_loc = '0;
		bank = i_bank;
		gpr1_hi = i_large ? `BMD_GPR1_HI_LARGE : `BMD_GPR1_HI_SMALL;
		if (i_off >= `BMD_COMMON_LO) begin
			bank = 2'h0;
		end
		if (i_off <= `BMD_SFR_TOP) begin
			o_loc.is_sfr = 1'b1;
			unique case (i_off)
				7'h02, 7'h0a, 7'h0b: bank = 2'h0;
				7'h01:               bank = {1'b0, i_bank[0]};
				default:             bank = i_bank;
			endcase
			o_loc.sfr_idx = {bank, i_off[4:0]};
		end else begin
			unique case (bank)
				2'h0: begin
					o_loc.is_gpr  = 1'b1;
					o_loc.gpr_idx = `BMD_GPR0_BASE + {1'b0, i_off - `BMD_GPR0_LO};
				end
				2'h1: begin
					o_loc.is_gpr  = (i_off <= gpr1_hi);
					o_loc.gpr_idx = `BMD_GPR1_BASE + {1'b0, i_off - `BMD_GPR1_LO};
				end
				2'h2: begin
					o_loc.is_gpr  = i_large && (i_off <= `BMD_GPR2_HI_LARGE);
					o_loc.gpr_idx = `BMD_GPR2_BASE + {1'b0, i_off - `BMD_GPR2_LO};
				end
				2'h3: begin
					o_loc.is_gpr  = 1'b0;
					o_loc.gpr_idx = 8'h00;
				end
			endcase
		end
	end

endmodule

`default_nettype wire

// *** bmd_decoder.sv ***
/*
 banked data-memory decoder: avalon-mm slave giving the core its file
 locations, with bank select, mirrors, common area and indirect access.
 assumes one 10 mhz clock, synchronous active-high reset, a master that
 holds each request until it sees waitrequest low.
*/
// The Avalon-MM interface to the registers was left to the implementer.
// Overview of operation
// - two select bits pick one of four banks
// - bank joins 7-bit offset, 128 locations
// - lowest offsets decode to special registers
// - higher offsets are static general storage; the code has none in bank 3 and leaves parts of banks 1 and 2 unimplemented
// - every bank holds special registers
// - mirrored specials share one physical register
// - storage is 128 or 192 bytes
// - direct or pointer-based indirect access everywhere
// - special registers keep values until rewritten
`include "bmd_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module bmd_decoder #(
	parameter bit LARGE = 1'b1
) (
	input  wire logic        i_clk,
	input  wire logic        i_rst,
	input  wire logic [6:0]  i_address,
	input  wire logic        i_read,
	input  wire logic        i_write,
	input  wire logic [31:0] i_writedata,
	output logic      [31:0] o_readdata,
	output logic             o_waitrequest,
	output logic      [1:0]  o_bank,
	output logic      [7:0]  o_core_status,
	output logic      [7:0]  o_indirect_pointer
);

	bmd_pkg::bmd_state_t st;
	bmd_pkg::bmd_state_t next_st;
	bmd_pkg::bmd_loc_t   loc;
	bmd_pkg::bmd_bank_t  bank;
	bmd_pkg::bmd_off_t   off;
	logic                null_acc;
	logic [7:0]          rval;
	logic [8:0]          full_addr;

	always_comb begin
		null_acc  = 1'b0;
		full_addr = '0;
		bank = {st.status[`BMD_BANK_HI_BIT], st.status[`BMD_BANK_LO_BIT]};
		off  = i_address;
		if (i_address == `BMD_OFF_INDIRECT) begin
			full_addr = {st.status[`BMD_IND_BANK_BIT], st.pointer};
			bank = full_addr[8:7];
			off  = full_addr[6:0];
			// pointing at the indirect slot itself reads zero, writes nothing
			null_acc = (off == `BMD_OFF_INDIRECT);
		end
	end

	bmd_map u_map (
		.i_large (LARGE),
		.i_bank  (bank),
		.i_off   (off),
		.o_loc   (loc)
	);

	always_comb begin
		rval = `BMD_UNMAPPED_DATA;
		if (null_acc) begin
			rval = `BMD_UNMAPPED_DATA;
		end else if (off == `BMD_OFF_STATUS) begin
			rval = st.status;
		end else if (off == `BMD_OFF_POINTER) begin
			rval = st.pointer;
		end else if (loc.is_sfr) begin
			rval = st.special_function_location[loc.sfr_idx];
		end else if (loc.is_gpr) begin
			rval = st.general_storage_location[loc.gpr_idx];
		end
	end

	always_comb begin
		next_st = st;
		if ((i_read || i_write) && st.waitreq) begin
			// first edge: fetch data, then drop waitrequest
			next_st.waitreq = 1'b0;
			next_st.rdata   = i_read ? rval : st.rdata;
		end else if ((i_read || i_write) && !st.waitreq) begin
			// transfer completes here; waitrequest rises, so a request held at the next edge starts a new fetch at once
			next_st.waitreq = 1'b1;
			if (i_write && !null_acc) begin
				if (off == `BMD_OFF_STATUS) begin
					next_st.status = i_writedata[7:0];
				end else if (off == `BMD_OFF_POINTER) begin
					next_st.pointer = i_writedata[7:0];
				end else if (loc.is_sfr) begin
					next_st.special_function_location[loc.sfr_idx] = i_writedata[7:0];
				end else if (loc.is_gpr) begin
					next_st.general_storage_location[loc.gpr_idx] = i_writedata[7:0];
				end
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			st         <= '0;
			st.waitreq <= 1'b1;
			st.status  <= `BMD_STATUS_RST;
			st.pointer <= `BMD_POINTER_RST;
		end else begin
			st <= next_st;
		end
	end

	assign o_readdata         = {24'h000000, st.rdata};
	assign o_waitrequest      = st.waitreq;
	assign o_bank             = {st.status[`BMD_BANK_HI_BIT], st.status[`BMD_BANK_LO_BIT]};
	assign o_core_status      = st.status;
	assign o_indirect_pointer = st.pointer;

endmodule

`default_nettype wire

// *** bmd_decoder_monitor.sv ***
/* port checker of the decoder.
 assumes a bind onto bmd_decoder. */
`timescale 1ns/1ps
`default_nettype none
module bmd_mon (
	input wire logic        i_clk,
	input wire logic        i_rst,
	input wire logic [6:0]  i_address,
	input wire logic        i_read,
	input wire logic        i_write,
	input wire logic [31:0] i_writedata,
	input wire logic [31:0] o_readdata,
	input wire logic        o_waitrequest,
	input wire logic [1:0]  o_bank,
	input wire logic [7:0]  o_core_status,
	input wire logic [7:0]  o_indirect_pointer
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);
	a_bank_follow: assert property (o_bank == o_core_status[6:5])
		else $error("bank off status");
	a_status_take: assert property (i_write && !o_waitrequest && i_address == 7'h03
		|=> o_core_status == $past(i_writedata[7:0])) else $error("status not written");
	a_pointer_take: assert property (i_write && !o_waitrequest && i_address == 7'h04
		|=> o_indirect_pointer == $past(i_writedata[7:0])) else $error("pointer not written");
	a_status_keep: assert property (!(i_write && (i_address == 7'h03 || i_address == 7'h00))
		|=> $stable(o_core_status)) else $error("status drifted");
	a_byte_lane: assert property (!o_waitrequest |-> o_readdata[31:8] == 24'h0)
		else $error("upper lanes set");
	a_answer_next: assert property ((i_read || i_write) && o_waitrequest |=> !o_waitrequest)
		else $error("no answer");
	a_one_cycle: assert property (!o_waitrequest |=> o_waitrequest)
		else $error("wait low too long");
	a_bank3_empty: assert property (i_read && !o_waitrequest && o_bank == 2'h3
		&& i_address == 7'h20 |-> o_readdata[7:0] == 8'h00) else $error("bank 3 storage");
endmodule
bind bmd_decoder bmd_mon u_mon (.*);
`default_nettype wire

// *** bmd_core_model.sv ***
/* core model issuing file accesses as avalon master.
 assumes the bench calls acc and watches to. */
`timescale 1ns/1ps
`default_nettype none
module bmd_core (
	input  wire logic        i_clk,
	input  wire logic [31:0] i_readdata,
	input  wire logic        i_waitrequest,
	output logic      [6:0]  o_address = 7'h00,
	output logic             o_read = 1'b0,
	output logic             o_write = 1'b0,
	output logic      [31:0] o_writedata = 32'h0
);
	logic to = 1'b0;
	task automatic acc(input logic w, input logic [6:0] a, input logic [7:0] d,
		output logic [7:0] q);
		int n;
		n = 0;
		@(posedge i_clk);
		o_address <= a;
		o_read <= !w;
		o_write <= w;
		o_writedata <= {24'h0, d};
		do begin
			@(posedge i_clk);
			n++;
		end while (i_waitrequest && n < 50);
		q = i_readdata[7:0];
		to = to | i_waitrequest;
		o_read <= 1'b0;
		o_write <= 1'b0;
		// released lines show junk, never the last value
		o_writedata <= ~o_writedata;
		o_address <= ~a;
	endtask
endmodule
`default_nettype wire

// *** bmd_decoder_tb.sv ***
/* self-checking bench of the decoder.
 assumes the core model drives the bus. */
`timescale 1ns/1ps
`default_nettype none
module bmd_decoder_tb;
	logic        i_clk;
	logic        i_rst;
	logic [6:0]  a;
	logic        rd;
	logic        wr;
	logic [31:0] wd;
	logic [31:0] rdat;
	logic        wq;
	logic [1:0]  bank;
	logic [7:0]  st;
	logic [7:0]  q;
	logic [7:0]  ptr;
	int          num_errors = 0;
	int          check_count = 0;
	bmd_decoder #(.LARGE(1'b1)) u_dut (.i_clk(i_clk), .i_rst(i_rst), .i_address(a),
		.i_read(rd), .i_write(wr), .i_writedata(wd), .o_readdata(rdat),
		.o_waitrequest(wq), .o_bank(bank), .o_core_status(st), .o_indirect_pointer(ptr));
	bmd_core u_core (.i_clk(i_clk), .i_readdata(rdat), .i_waitrequest(wq),
		.o_address(a), .o_read(rd), .o_write(wr), .o_writedata(wd));
	initial begin
		i_clk = 1'b0;
		forever #50 i_clk = ~i_clk;
	end
	task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
		check_count++;
		if (s !== e) begin
			num_errors++;
			$display("[FAIL] %s exp %h seen %h", n, e, s);
		end
	endtask
	task automatic complete_run();
		$display("errors %0d checks %0d", num_errors, check_count);
		if (num_errors == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	always @(posedge u_core.to) begin
		num_errors++;
		complete_run();
	end
	task automatic w(input logic [6:0] ad, input logic [7:0] d);
		u_core.acc(1'b1, ad, d, q);
	endtask
	task automatic r(input logic [6:0] ad);
		u_core.acc(1'b0, ad, 8'h00, q);
	endtask
	// status is mirrored, so bank can be set from any bank
	task automatic sb(input logic [1:0] b);
		w(7'h03, {1'b0, b, 5'h00});
		#1;
	endtask
	task automatic t_banks();
		for (int b = 0; b < 4; b++) begin
			sb(2'(b));
			chk("bank", {6'h0, bank}, 8'(b));
			w(7'h20, 8'h10 + 8'(b));
		end
		for (int b = 0; b < 4; b++) begin
			sb(2'(b));
			r(7'h20);
			chk("storage", q, (b < 3) ? 8'h10 + 8'(b) : 8'h00);
		end
	endtask
	task automatic t_mirror();
		sb(2'h2);
		w(7'h0a, 8'h5a);
		sb(2'h0);
		r(7'h0a);
		chk("mirror", q, 8'h5a);
		w(7'h05, 8'hc3);
		sb(2'h3);
		w(7'h05, 8'h3c);
		sb(2'h0);
		r(7'h05);
		chk("special", q, 8'hc3);
	endtask
	task automatic t_common();
		sb(2'h3);
		w(7'h75, 8'ha5);
		sb(2'h0);
		r(7'h75);
		chk("common", q, 8'ha5);
		// bank 2 storage ends at 2fh, 30h is unimplemented
		sb(2'h2);
		w(7'h30, 8'h66);
		r(7'h30);
		chk("bank2 edge", q, 8'h00);
		r(7'h2f);
		chk("bank2 top", q, 8'h00);
		sb(2'h0);
	endtask
	task automatic t_indirect();
		w(7'h04, 8'h20);
		#1;
		chk("pointer", ptr, 8'h20);
		r(7'h00);
		chk("indirect", q, 8'h10);
		// status bit 7 lifts the pointer into banks 2 and 3
		w(7'h03, 8'h80);
		r(7'h00);
		chk("indirect high", q, 8'h12);
		sb(2'h0);
		w(7'h00, 8'h77);
		r(7'h20);
		chk("direct", q, 8'h77);
	endtask
	initial begin
		i_rst = 1'b1;
		repeat (5) @(posedge i_clk);
		i_rst <= 1'b0;
		chk("status", st, 8'h00);
		t_banks();
		t_mirror();
		t_common();
		t_indirect();
		complete_run();
	end
endmodule
`default_nettype wire
